// *** design/cfh_pkg.sv ***
// shared constants and types of the card host control block
package cfh_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // least hold of the internal card reset
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least busy time after reset before ready
  localparam int BUSY_NS = 20000;
  localparam int BUSY_CYC = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  localparam int PIN_W = 3;
  localparam int PIN_RST = 0;
  localparam int PIN_ATA_SEL_N = 1;
  localparam int PIN_DMACK_N = 2;
  // idle pin levels: pulled-up inputs read high
  localparam logic [PIN_W-1:0] PIN_IDLE = 3'h7;

  // ----------------------------------------------------------------
  // output idle levels
  // ----------------------------------------------------------------
  localparam logic WAIT_IDLE = 1'h1;
  localparam logic WP_IDLE = 1'h1;
  localparam logic STROBE_IDLE = 1'h1;

  // ----------------------------------------------------------------
  // modes and reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFH_MODE_MEM = 2'h0,
    CFH_MODE_IO  = 2'h1,
    CFH_MODE_ATA = 2'h2
  } cfh_mode_t;

  typedef enum logic [1:0] {
    CFH_ST_RESET = 2'h0,
    CFH_ST_BUSY  = 2'h1,
    CFH_ST_READY = 2'h2
  } cfh_rst_st_t;

endpackage

// *** design/cfh_rst_if.sv ***
// reset request and status between the control top and the reset sequencer
`timescale 1ns/10ps
interface cfh_rst_if;
  logic rst_req;
  logic card_rst;
  logic ready;
  logic init_done;

  modport gen (
    input rst_req,
    output card_rst,
    output ready,
    output init_done
  );

  modport ctl (
    output rst_req,
    input card_rst,
    input ready,
    input init_done
  );
endinterface

// *** design/cfh_sync.sv ***
// three-stage pin synchroniser with agree filter
`timescale 1ns/10ps
module cfh_sync #(
  parameter int W = cfh_pkg::PIN_W,
  parameter logic [W-1:0] IDLE = cfh_pkg::PIN_IDLE
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins in, filtered levels out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl
);
  import cfh_pkg::*;

  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
    logic [W-1:0] q3;
    logic [W-1:0] o;
  } cfh_sync_st_t;

  cfh_sync_st_t st_ff;
  cfh_sync_st_t nxt_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.q1 = pin;
    nxt_st.q2 = st_ff.q1;
    nxt_st.q3 = st_ff.q2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.q2[i] == st_ff.q3[i]) begin
        nxt_st.o[i] = st_ff.q3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= {IDLE, IDLE, IDLE, IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lvl = st_ff.o;
endmodule

// *** design/cfh_rstgen.sv ***
// card reset sequencer: power-up reset, hold and busy time
`timescale 1ns/10ps
module cfh_rstgen #(
  parameter int HOLD_CYC = cfh_pkg::RST_HOLD_CYC,
  parameter int BUSY_CYCLES = cfh_pkg::BUSY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // request and status
  cfh_rst_if.gen rif
);
  import cfh_pkg::*;

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] BUSY_LAST = CNT_W'(BUSY_CYCLES - 1);

  typedef struct packed {
    cfh_rst_st_t state;
    logic [CNT_W-1:0] cnt;
    logic card_rst;
    logic ready;
    logic init_done;
  } cfh_rg_st_t;

  cfh_rg_st_t st_ff;
  cfh_rg_st_t nxt_st;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.state)
      CFH_ST_RESET: begin
        if (!rif.rst_req && st_ff.cnt >= HOLD_LAST) begin
          nxt_st.state = CFH_ST_BUSY;
          nxt_st.cnt = '0;
        end else if (st_ff.cnt < HOLD_LAST) begin
          nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
      end
      CFH_ST_BUSY: begin
        if (rif.rst_req) begin
          nxt_st.state = CFH_ST_RESET;
          nxt_st.cnt = '0;
        end else if (st_ff.cnt >= BUSY_LAST) begin
          nxt_st.state = CFH_ST_READY;
          nxt_st.cnt = '0;
        end else begin
          nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
      end
      CFH_ST_READY: begin
        if (rif.rst_req) begin
          nxt_st.state = CFH_ST_RESET;
          nxt_st.cnt = '0;
        end
      end
      default: begin
        nxt_st.state = CFH_ST_RESET;
        nxt_st.cnt = '0;
      end
    endcase
    nxt_st.card_rst = (nxt_st.state == CFH_ST_RESET);
    nxt_st.ready = (nxt_st.state == CFH_ST_READY);
    nxt_st.init_done = (nxt_st.state == CFH_ST_READY);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{state: CFH_ST_RESET, cnt: '0, card_rst: 1'h1, ready: 1'h0, init_done: 1'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rif.card_rst = st_ff.card_rst;
  assign rif.ready = st_ff.ready;
  assign rif.init_done = st_ff.init_done;
endmodule

// *** design/cfh_ctl.sv ***
// host port control and status signalling of the card
// Functional notes
// - ignore DMA acknowledge unless DMA active
// - memory/IO modes: reset while pin high
// - reset pin high from power-up ignored
// - soft reset bit resets like pin
// - ATA mode: reset pin active low
// - wait low stretches host cycle
// - ATA non-UDMA: wait pin is IORDY
// - UDMA write: DDMARDY asserted, deassert pauses
// - UDMA read: strobe edges latch data
// - memory mode: write protect low after init
// - IO mode: port-width indicator low for 16-bit
// - ATA mode: 16-bit indicator low for words
// - ready low until reset processing done
`timescale 1ns/10ps
module cfh_ctl #(
  parameter int HOLD_CYC = cfh_pkg::RST_HOLD_CYC,
  parameter int BUSY_CYCLES = cfh_pkg::BUSY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host pins in
  input wire logic rst_pin,
  input wire logic ata_sel_n_pin,
  input wire logic dmack_n_pin,
  // core configuration
  input wire logic cfg_io_mode,
  input wire logic cfg_soft_rst,
  // core transfer status
  input wire logic core_stretch,
  input wire logic core_port16,
  input wire logic core_word_xfer,
  // core dma status
  input wire logic dma_active,
  input wire logic udma_write,
  input wire logic udma_read,
  input wire logic udma_accept,
  input wire logic udma_send,
  // host pins out
  output logic wait_pin,
  output logic wp_pin,
  output logic ready_pin,
  // core side out
  output logic card_rst,
  output logic dma_ack,
  output logic strobe_edge,
  output cfh_pkg::cfh_mode_t mode
);
  import cfh_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFH_UD_IDLE = 2'h0,
    CFH_UD_WRITE = 2'h1,
    CFH_UD_READ = 2'h2
  } cfh_udma_t;

  // disk-style personality
  function automatic logic is_ata(input cfh_mode_t m);
    return m == CFH_MODE_ATA;
  endfunction

  // ultra dma direction, write wins over read
  function automatic cfh_udma_t udma_phase(input cfh_mode_t m, input logic act, input logic wr, input logic rd);
    cfh_udma_t ph;
    ph = CFH_UD_IDLE;
    if (is_ata(m) && act) begin
      if (wr) begin
        ph = CFH_UD_WRITE;
      end else if (rd) begin
        ph = CFH_UD_READ;
      end
    end
    return ph;
  endfunction

  // personality from pin and configuration
  function automatic cfh_mode_t pick_mode(input logic ata, input logic io_cfg, input logic rst);
    cfh_mode_t m;
    m = CFH_MODE_MEM;
    if (ata) begin
      m = CFH_MODE_ATA;
    end else if (io_cfg && !rst) begin
      m = CFH_MODE_IO;
    end
    return m;
  endfunction

  // reset request from the host pin
  function automatic logic host_reset(input logic ata, input logic lvl, input logic armed);
    logic r;
    if (ata) begin
      r = !lvl;
    end else begin
      r = lvl && armed;
    end
    return r;
  endfunction

  function automatic logic ack_taken(input cfh_mode_t m, input logic act, input logic rst, input logic lvl);
    return is_ata(m) && act && !rst && lvl;
  endfunction

  // wait, ready or pause pin level per personality
  function automatic logic wait_level(input cfh_mode_t m, input cfh_udma_t ph, input logic stretch,
    input logic accept, input logic strobe);
    logic lvl;
    lvl = WAIT_IDLE;
    case (m)
      CFH_MODE_MEM, CFH_MODE_IO: begin
        lvl = !stretch;
      end
      CFH_MODE_ATA: begin
        if (ph == CFH_UD_WRITE) begin
          lvl = !accept;
        end else if (ph == CFH_UD_READ) begin
          lvl = strobe;
        end else begin
          lvl = !stretch;
        end
      end
      default: begin
        lvl = WAIT_IDLE;
      end
    endcase
    return lvl;
  endfunction

  // protect or width pin level per personality
  function automatic logic wp_level(input cfh_mode_t m, input logic done, input logic p16, input logic word);
    logic lvl;
    lvl = WP_IDLE;
    case (m)
      CFH_MODE_MEM: begin
        lvl = !done;
      end
      CFH_MODE_IO: begin
        lvl = !p16;
      end
      CFH_MODE_ATA: begin
        lvl = !word;
      end
      default: begin
        lvl = WP_IDLE;
      end
    endcase
    return lvl;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic armed;
    cfh_mode_t mode;
    logic wait_pin;
    logic wp_pin;
    logic dstrobe;
    logic strobe_edge;
    logic dma_ack;
  } cfh_ctl_st_t;

  cfh_ctl_st_t st_ff;
  cfh_ctl_st_t nxt_st;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_lvl;
  logic rst_lvl;
  logic ata_lvl;
  logic dmack_lvl;
  logic in_reset;
  logic udma_rd_on;
  logic hw_rst;
  cfh_udma_t udma_ph;

  cfh_rst_if rif ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    pin_raw = PIN_IDLE;
    pin_raw[PIN_RST] = rst_pin;
    pin_raw[PIN_ATA_SEL_N] = ata_sel_n_pin;
    pin_raw[PIN_DMACK_N] = dmack_n_pin;
  end

  cfh_sync #(
    .W(PIN_W),
    .IDLE(PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin(pin_raw),
    .lvl(pin_lvl)
  );

  assign rst_lvl = pin_lvl[PIN_RST];
  assign ata_lvl = !pin_lvl[PIN_ATA_SEL_N];
  assign dmack_lvl = !pin_lvl[PIN_DMACK_N];

  // ----------------------------------------------------------------
  // reset request
  // ----------------------------------------------------------------
  assign hw_rst = host_reset(ata_lvl, rst_lvl, st_ff.armed);

  assign rif.rst_req = hw_rst || cfg_soft_rst;

  cfh_rstgen #(
    .HOLD_CYC(HOLD_CYC),
    .BUSY_CYCLES(BUSY_CYCLES)
  ) u_rstgen (
    .clk(clk),
    .arst_n(arst_n),
    .rif(rif)
  );

  assign in_reset = rif.card_rst;
  assign udma_ph = udma_phase(st_ff.mode, dma_active, udma_write, udma_read);
  assign udma_rd_on = (udma_ph == CFH_UD_READ);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe_edge = 1'h0;

    // pin counts only after seen low
    if (!rst_lvl) begin
      nxt_st.armed = 1'h1;
    end

    // mode select
    nxt_st.mode = pick_mode(ata_lvl, cfg_io_mode, in_reset);

    nxt_st.dma_ack = ack_taken(st_ff.mode, dma_active, in_reset, dmack_lvl);

    // strobe idles outside UDMA read
    if (!udma_rd_on || in_reset) begin
      nxt_st.dstrobe = STROBE_IDLE;
    end else if (udma_send) begin
      nxt_st.dstrobe = !st_ff.dstrobe;
      nxt_st.strobe_edge = 1'h1;
    end

    // wait pin
    if (in_reset) begin
      nxt_st.wait_pin = WAIT_IDLE;
    end else begin
      nxt_st.wait_pin = wait_level(st_ff.mode, udma_ph, core_stretch, udma_accept, nxt_st.dstrobe);
    end

    // write protect / width indicator
    if (in_reset) begin
      nxt_st.wp_pin = WP_IDLE;
    end else begin
      nxt_st.wp_pin = wp_level(st_ff.mode, rif.init_done, core_port16, core_word_xfer);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{armed: 1'h0, mode: CFH_MODE_MEM, wait_pin: WAIT_IDLE, wp_pin: WP_IDLE,
                 dstrobe: STROBE_IDLE, strobe_edge: 1'h0, dma_ack: 1'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wait_pin = st_ff.wait_pin;
  assign wp_pin = st_ff.wp_pin;
  assign ready_pin = rif.ready;
  assign card_rst = rif.card_rst;
  assign dma_ack = st_ff.dma_ack;
  assign strobe_edge = st_ff.strobe_edge;
  assign mode = st_ff.mode;
endmodule

// *** verif/cfh_ctl_properties.sv ***
// concurrent checks on the ports of the card host control block
`timescale 1ns/10ps
module cfh_props
  import cfh_pkg::*;
#(
  parameter int HOLD_CYC = RST_HOLD_CYC,
  parameter int BUSY_CYCLES = BUSY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host pins in
  input wire logic rst_pin,
  input wire logic ata_sel_n_pin,
  input wire logic dmack_n_pin,
  // core inputs
  input wire logic cfg_io_mode,
  input wire logic cfg_soft_rst,
  input wire logic core_stretch,
  input wire logic core_port16,
  input wire logic core_word_xfer,
  input wire logic dma_active,
  input wire logic udma_write,
  input wire logic udma_read,
  input wire logic udma_accept,
  input wire logic udma_send,
  // outputs
  input wire logic wait_pin,
  input wire logic wp_pin,
  input wire logic ready_pin,
  input wire logic card_rst,
  input wire logic dma_ack,
  input wire logic strobe_edge,
  input cfh_pkg::cfh_mode_t mode
);
  // ----------------------------------------------------------------
  // mode qualifiers
  // ----------------------------------------------------------------
  wire mem_on = mode == CFH_MODE_MEM && !card_rst;
  wire io_on = mode == CFH_MODE_IO && !card_rst;
  wire ata_on = mode == CFH_MODE_ATA && !card_rst;
  wire rd_on = ata_on && dma_active && udma_read && !udma_write;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  busy_ready_a: assert property (card_rst |-> !ready_pin)
    else $error("ready high during card reset");
  busy_time_a: assert property ($fell(card_rst) |-> !ready_pin [*3])
    else $error("ready too soon after reset");
  rst_idle_a: assert property (card_rst && $past(card_rst) |-> wait_pin && wp_pin)
    else $error("outputs not idle in reset");
  dmack_ignore_a: assert property (!$past(dma_active) |-> !dma_ack)
    else $error("acknowledge taken without dma");
  dmack_take_a: assert property ((ata_on && dma_active && !dmack_n_pin) [*7] |-> dma_ack)
    else $error("acknowledge not taken");
  wait_mem_a: assert property ((mem_on && core_stretch && !udma_write && !udma_read) ##1 mem_on |-> !wait_pin)
    else $error("wait not low on stretch");
  iordy_a: assert property ((ata_on && core_stretch && !udma_write && !udma_read) ##1 ata_on |-> !wait_pin)
    else $error("ready line not low on stretch");
  wp_io_a: assert property ((io_on && core_port16) ##1 io_on |-> !wp_pin)
    else $error("port width flag not low");
  wp_ata_a: assert property ((ata_on && core_word_xfer) ##1 ata_on |-> !wp_pin)
    else $error("word flag not low");
  wp_mem_a: assert property ((mem_on && ready_pin) ##1 (mem_on && ready_pin) |-> !wp_pin)
    else $error("protect not low after init");
  ddmardy_a: assert property ((ata_on && dma_active && udma_write) ##1 ata_on |-> wait_pin == !$past(udma_accept))
    else $error("accept level wrong");
  strobe_a: assert property (rd_on ##1 (rd_on && udma_send) ##1 ata_on |-> strobe_edge && $changed(wait_pin))
    else $error("strobe did not toggle");
endmodule

bind cfh_ctl cfh_props #(.HOLD_CYC(HOLD_CYC), .BUSY_CYCLES(BUSY_CYCLES)) i_cfh_props (
  .clk, .arst_n, .rst_pin, .ata_sel_n_pin, .dmack_n_pin, .cfg_io_mode, .cfg_soft_rst, .core_stretch,
  .core_port16, .core_word_xfer, .dma_active, .udma_write, .udma_read, .udma_accept, .udma_send,
  .wait_pin, .wp_pin, .ready_pin, .card_rst, .dma_ack, .strobe_edge, .mode
);

// *** verif/cfh_host.sv ***
// host controller model driving the card's reset, mode and acknowledge pins
`timescale 1ns/10ps
module cfh_host (
  // clock
  input wire logic clk,
  // wishes of the bench
  input wire logic ata,
  input wire logic rst,
  input wire logic dma,
  input wire logic ack,
  // pins to the card
  output logic rst_pin = 1'h1,
  output logic ata_sel_n_pin = 1'h1,
  output logic dmack_n_pin = 1'h1
);
  // no write strobe reaches this block
  always @(posedge clk) begin
    ata_sel_n_pin <= !ata;
    rst_pin <= ata ? !rst : rst;
    // dma host drives it from ack, non-dma disk host holds it high, others toggle it every cycle
    dmack_n_pin <= dma ? !ack : (ata ? 1'h1 : !dmack_n_pin);
  end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the card host control block
`timescale 1ns/10ps
module tb_top;
  import cfh_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic h_ata = 1'h0, h_rst = 1'h1, h_dma = 1'h0, h_ack = 1'h0;
  logic rst_pin, ata_sel_n_pin, dmack_n_pin;
  logic cfg_io_mode = 1'h0, cfg_soft_rst = 1'h0, core_stretch = 1'h0, core_port16 = 1'h0;
  logic core_word_xfer = 1'h0, dma_active = 1'h0, udma_write = 1'h0, udma_read = 1'h0;
  logic udma_accept = 1'h0, udma_send = 1'h0;
  logic wait_pin, wp_pin, ready_pin, card_rst, dma_ack, strobe_edge;
  cfh_mode_t mode;
  int bad_count = 0, cmp_count = 0, cyc_count = 0;

  always #5 clk = ~clk;

  cfh_host i_cfh_host (.clk, .ata(h_ata), .rst(h_rst), .dma(h_dma), .ack(h_ack), .rst_pin, .ata_sel_n_pin,
    .dmack_n_pin);
  cfh_ctl #(.HOLD_CYC(2), .BUSY_CYCLES(4)) i_cfh_ctl (.clk, .arst_n, .rst_pin, .ata_sel_n_pin, .dmack_n_pin,
    .cfg_io_mode, .cfg_soft_rst, .core_stretch, .core_port16, .core_word_xfer, .dma_active, .udma_write,
    .udma_read, .udma_accept, .udma_send, .wait_pin, .wp_pin, .ready_pin, .card_rst, .dma_ack, .strobe_edge,
    .mode);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 100 && ready_pin !== 1'h1; i++) cyc(1);
    chk(ready_pin, 8'h1);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    cyc(1);
    chk(ready_pin, 8'h0);
    wait_ready();
    chk(card_rst, 8'h0);
    cyc(2);
    chk(wp_pin, 8'h0);
    chk({6'h0, mode}, 8'h0);
  endtask

  task automatic t_pin_reset();
    @(posedge clk) h_rst <= 1'h0;
    cyc(10);
    @(posedge clk) h_rst <= 1'h1;
    cyc(10);
    chk(card_rst, 8'h1);
    chk(ready_pin, 8'h0);
    cyc(20);
    chk(card_rst, 8'h1);
    @(posedge clk) h_rst <= 1'h0;
    wait_ready();
    @(posedge clk) cfg_soft_rst <= 1'h1;
    cyc(3);
    chk(card_rst, 8'h1);
    cyc(10);
    chk(card_rst, 8'h1);
    @(posedge clk) cfg_soft_rst <= 1'h0;
    wait_ready();
  endtask

  task automatic t_mem_io();
    @(posedge clk) core_stretch <= 1'h1;
    cyc(2);
    chk(wait_pin, 8'h0);
    @(posedge clk) core_stretch <= 1'h0;
    cyc(2);
    chk(wait_pin, 8'h1);
    @(posedge clk) cfg_io_mode <= 1'h1;
    core_port16 <= 1'h1;
    cyc(3);
    chk({6'h0, mode}, 8'h1);
    chk(wp_pin, 8'h0);
    @(posedge clk) core_port16 <= 1'h0;
    cyc(2);
    chk(wp_pin, 8'h1);
    @(posedge clk) cfg_io_mode <= 1'h0;
  endtask

  task automatic t_ata();
    @(posedge clk) h_ata <= 1'h1;
    cyc(12);
    wait_ready();
    chk({6'h0, mode}, 8'h2);
    @(posedge clk) h_rst <= 1'h1;
    cyc(10);
    chk(card_rst, 8'h1);
    @(posedge clk) h_rst <= 1'h0;
    wait_ready();
    @(posedge clk) core_word_xfer <= 1'h1;
    core_stretch <= 1'h1;
    cyc(2);
    chk(wp_pin, 8'h0);
    chk(wait_pin, 8'h0);
    @(posedge clk) core_word_xfer <= 1'h0;
    core_stretch <= 1'h0;
    cyc(8);
    chk(wp_pin, 8'h1);
    chk(wait_pin, 8'h1);
    chk(dma_ack, 8'h0);
    @(posedge clk) h_dma <= 1'h1;
    h_ack <= 1'h1;
    dma_active <= 1'h1;
    cyc(10);
    chk(dma_ack, 8'h1);
    @(posedge clk) dma_active <= 1'h0;
    cyc(2);
    chk(dma_ack, 8'h0);
    @(posedge clk) dma_active <= 1'h1;
    udma_write <= 1'h1;
    udma_accept <= 1'h1;
    cyc(2);
    chk(wait_pin, 8'h0);
    @(posedge clk) udma_accept <= 1'h0;
    cyc(2);
    chk(wait_pin, 8'h1);
    @(posedge clk) udma_write <= 1'h0;
    udma_read <= 1'h1;
    cyc(2);
    chk(wait_pin, 8'h1);
    @(posedge clk) udma_send <= 1'h1;
    cyc(1);
    chk(wait_pin, 8'h0);
    chk(strobe_edge, 8'h1);
    @(posedge clk) udma_send <= 1'h0;
    #1;
    chk(wait_pin, 8'h1);
    cyc(1);
    chk(strobe_edge, 8'h0);
    @(posedge clk) udma_read <= 1'h0;
    dma_active <= 1'h0;
    h_dma <= 1'h0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    t_powerup();
    t_pin_reset();
    t_mem_io();
    t_ata();
    finish_test();
  end
endmodule
